// file: logic/adc_serial_port_sequencer.sv
// converter conversion control, serial port and channel sequencer
//
// Contract
// - conversion_start rising begins conversion, floats output, ignores config input.
// - a started conversion always runs to its end.
// - after conversion, conversion_start falling presents the result msb.
// - config word captured msb first on first 14 rising clocks while low.
// - no-busy mode shifts msb-1 onward on first 15 falling clocks.
// - partial config words are discarded; current configuration kept.
// - result not read before next safe window closes is lost.
// - no-busy output floats at 16th (30th) fall or conversion_start rise.
// - readback appends the result's own config word, msb first.
// - busy mode drives output low at end of conversion.
// - busy mode shifts full result from msb on first 16 falls.
// - busy mode floats after 17th fall, otherwise last bit stays.
// - busy mode with readback floats after 31st fall.
// - sequencer scans input 0 to last channel, optional temperature, repeats.
// - paired scanning uses even inputs only.
// - changing pairing or last channel restarts the sequence.
// - configuration from phase n-1 applies in phase n from input 0.
// - after last channel, temperature if enabled, then input 0.
// - sequencer select: off, update, scan plus temperature, scan only.
// - conversion_start level at end of conversion selects busy mode.
`timescale 1ns/100ps
`include "adc_seq_defs.svh"

module adc_serial_port_sequencer #(
  parameter int CONV_CYCLES = `CONV_CYC,
  parameter int DATA_CYCLES = `DATA_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conversion_start,
  input wire logic serial_clock,
  input wire logic config_in,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  output logic [3:0] channel_select,
  output logic converting
);

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  localparam logic [15:0] DATA_LIM = 16'(DATA_CYCLES);

  // ==================================================================
  // pin synchronisers
  logic cnv_m, cnv_s, cnv_d;
  logic sck_m, sck_s, sck_d;
  logic din_m, din_s;
  logic cnv_rise, cnv_fall, sck_rise, sck_fall;

  // two stages before any logic; third stage only for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnv_m <= 1'b0;
      cnv_s <= 1'b0;
      cnv_d <= 1'b0;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      din_m <= 1'b0;
      din_s <= 1'b0;
    end else begin
      cnv_m <= conversion_start;
      cnv_s <= cnv_m;
      cnv_d <= cnv_s;
      sck_m <= serial_clock;
      sck_s <= sck_m;
      sck_d <= sck_s;
      din_m <= config_in;
      din_s <= din_m;
    end
  end

  assign cnv_rise = cnv_s & ~cnv_d;
  assign cnv_fall = ~cnv_s & cnv_d;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;

  // ==================================================================
  // conversion timing
  logic [15:0] conv_cnt_r;
  logic eoc, win_open, win_close;
  logic busy_mode_r;

  // later edges on the start pin are ignored until the count ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converting <= 1'b0;
      conv_cnt_r <= 16'h0000;
    end else if (!converting) begin
      if (cnv_rise) begin
        converting <= 1'b1;
        conv_cnt_r <= 16'h0000;
      end
    end else if (conv_cnt_r == CONV_LAST) begin
      converting <= 1'b0;
    end else begin
      conv_cnt_r <= conv_cnt_r + 16'h0001;
    end
  end

  assign eoc = converting && (conv_cnt_r == CONV_LAST);
  assign win_open = !converting || (conv_cnt_r < DATA_LIM);
  assign win_close = converting && (conv_cnt_r == DATA_LIM);

  // start pin level at the end of conversion picks the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_mode_r <= 1'b0;
    end else if (eoc) begin
      busy_mode_r <= !cnv_s;
    end
  end

  // ==================================================================
  // configuration input
  logic [13:0] cfg_sh_r;
  logic [3:0] rcnt_r;
  adc_seq_pkg::cfg_t cfg_r, cfg_conv_r, cfg_new;
  logic cfg_commit;

  // only the first 14 rising edges of a low period count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sh_r <= 14'h0000;
      rcnt_r <= 4'h0;
    end else if (cnv_fall || eoc) begin
      rcnt_r <= 4'h0;
    end else if (sck_rise && !cnv_s && win_open && rcnt_r < `CFG_BITS) begin
      cfg_sh_r <= {cfg_sh_r[12:0], din_s};
      rcnt_r <= rcnt_r + 4'h1;
    end
  end

  // a word that opens with a low bit is no update: an idle host keeps
  // config_in low while it reads, and that must not wipe the setup
  assign cfg_commit = eoc && (rcnt_r == `CFG_BITS) && cfg_sh_r[13];
  assign cfg_new = cfg_commit ? adc_seq_pkg::cfg_t'(cfg_sh_r) : cfg_r;

  // a short word never reaches the live configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= adc_seq_pkg::cfg_t'(`CFG_RESET);
    end else if (cfg_commit) begin
      cfg_r <= adc_seq_pkg::cfg_t'(cfg_sh_r);
    end
  end

  // the word in force when a conversion starts belongs to its result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_conv_r <= adc_seq_pkg::cfg_t'(`CFG_RESET);
    end else if (!converting && cnv_rise) begin
      cfg_conv_r <= cfg_r;
    end
  end

  // ==================================================================
  // channel sequencer
  logic temp_en_r;
  logic seq_restart;

  function automatic logic [3:0] next_channel(
    input logic [3:0] cur,
    input logic paired,
    input logic [2:0] last,
    input logic temp
  );
    logic [3:0] nxt;
    nxt = cur + (paired ? 4'h2 : 4'h1);
    if (cur == `TEMP_CH) begin
      next_channel = 4'h0;
    end else if (nxt > {1'b0, last}) begin
      next_channel = temp ? `TEMP_CH : 4'h0;
    end else begin
      next_channel = nxt;
    end
  endfunction

  // turning the scan on, or changing its shape, starts over at input 0
  assign seq_restart = cfg_commit &&
    ((cfg_r.sequencer_select == 2'b00) ||
     (cfg_new.single_channel != cfg_r.single_channel) ||
     (cfg_new.last_channel != cfg_r.last_channel));

  // select 01 keeps the temperature choice of the running scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_en_r <= 1'b0;
    end else if (cfg_commit && cfg_new.sequencer_select[1]) begin
      temp_en_r <= !cfg_new.sequencer_select[0];
    end
  end

  // channel steps at each end of conversion; select 00 loads the last channel instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select <= 4'h0;
    end else if (eoc) begin
      if (cfg_new.sequencer_select == 2'b00) begin
        channel_select <= {1'b0, cfg_new.last_channel};
      end else if (seq_restart) begin
        channel_select <= 4'h0;
      end else begin
        channel_select <= next_channel(channel_select,
          !cfg_new.single_channel, cfg_new.last_channel, temp_en_r);
      end
    end
  end

  // ==================================================================
  // sample store written by software, one word per channel
  logic [15:0] sample_mem [`CHANNELS];
  logic apb_setup, apb_wr;
  logic [3:0] sample_idx;
  logic sample_hit;

  assign apb_setup = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign sample_idx = paddr[5:2] - `SAMPLE_IDX_BASE;
  assign sample_hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) &&
    (paddr[5:2] >= `SAMPLE_IDX_BASE) && (sample_idx < 4'(`CHANNELS));

  // write takes effect on the edge that completes the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        sample_mem[i] <= 16'h0000;
      end
    end else if (apb_wr && sample_hit) begin
      sample_mem[sample_idx] <= pwdata[15:0];
    end
  end

  // ==================================================================
  // result frame
  adc_seq_pkg::frame_t frame_r;
  logic [29:0] sh_r;
  logic [4:0] fcnt_r, lim;
  logic frame_rb_r;

  assign lim = busy_mode_r ? (frame_rb_r ? `LIM_BUSY_RB : `LIM_BUSY) :
    (frame_rb_r ? `LIM_PLAIN_RB : `LIM_PLAIN);

  // a new result overwrites whatever was not read: unread data is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= adc_seq_pkg::FR_IDLE;
      sh_r <= 30'h00000000;
      fcnt_r <= 5'h00;
      frame_rb_r <= 1'b0;
      serial_result_out <= 1'b0;
      serial_result_oe_n <= 1'b1;
    end else if (cnv_rise) begin
      serial_result_oe_n <= 1'b1;
    end else if (eoc) begin
      sh_r <= {sample_mem[channel_select], cfg_conv_r};
      fcnt_r <= 5'h00;
      frame_rb_r <= !cfg_conv_r.readback_disable;
      if (!cnv_s) begin
        frame_r <= adc_seq_pkg::FR_SHIFT;
        serial_result_out <= 1'b0;
        serial_result_oe_n <= 1'b0;
      end else begin
        frame_r <= adc_seq_pkg::FR_ARMED;
        serial_result_oe_n <= 1'b1;
      end
    end else if (win_close) begin
      frame_r <= adc_seq_pkg::FR_IDLE;
    end else begin
      unique case (frame_r)
        adc_seq_pkg::FR_IDLE: begin
          fcnt_r <= fcnt_r;
        end
        adc_seq_pkg::FR_ARMED: begin
          if (cnv_fall) begin
            serial_result_out <= sh_r[29];
            sh_r <= {sh_r[28:0], 1'b0};
            serial_result_oe_n <= 1'b0;
            frame_r <= adc_seq_pkg::FR_SHIFT;
          end
        end
        adc_seq_pkg::FR_SHIFT: begin
          if (cnv_fall) begin
            serial_result_oe_n <= 1'b0; // resumes the held bit
          end else if (sck_fall && !cnv_s) begin
            fcnt_r <= fcnt_r + 5'h01;
            if (fcnt_r + 5'h01 == lim) begin
              serial_result_oe_n <= 1'b1;
              frame_r <= adc_seq_pkg::FR_IDLE;
            end else begin
              serial_result_out <= sh_r[29];
              sh_r <= {sh_r[28:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  // ==================================================================
  // apb slave: one wait state, data and ready both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (paddr == `OFF_CFG) begin
          prdata <= {18'h00000, cfg_r};
        end else if (paddr == `OFF_STATUS) begin
          prdata <= {24'h000000, busy_mode_r, converting,
            !serial_result_oe_n, 1'b0, channel_select};
        end else if (sample_hit) begin
          prdata <= {16'h0000, sample_mem[sample_idx]};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rise_float;
    cnv_rise |=> serial_result_oe_n;
  endproperty
  a_rise_float: assert property (p_rise_float)
    else $error("output not floated after start rise");

  property p_runs_on;
    converting && conv_cnt_r < CONV_LAST |=> converting;
  endproperty
  a_runs_on: assert property (p_runs_on)
    else $error("conversion ended early");

  property p_msb_out;
    frame_r == adc_seq_pkg::FR_ARMED && cnv_fall && !eoc && !win_close
      |=> !serial_result_oe_n && serial_result_out == $past(sh_r[29]);
  endproperty
  a_msb_out: assert property (p_msb_out)
    else $error("msb not presented on start fall");

  property p_capture;
    sck_rise && !cnv_s && !eoc && !cnv_fall && win_open &&
      rcnt_r < `CFG_BITS |=> cfg_sh_r[0] == $past(din_s) &&
      rcnt_r == $past(rcnt_r) + 4'h1;
  endproperty
  a_capture: assert property (p_capture)
    else $error("config bit not captured");

  property p_partial;
    eoc && rcnt_r != `CFG_BITS |=> $stable(cfg_r);
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial config word applied");

  property p_commit;
    cfg_commit |=> cfg_r == $past(cfg_sh_r) && rcnt_r == 4'h0;
  endproperty
  a_commit: assert property (p_commit)
    else $error("full config word not committed");

  property p_lost;
    win_close && !cnv_rise |=> frame_r == adc_seq_pkg::FR_IDLE;
  endproperty
  a_lost: assert property (p_lost)
    else $error("stale result still shifting");

  property p_float_count;
    frame_r == adc_seq_pkg::FR_SHIFT && sck_fall && !cnv_s && !cnv_rise &&
      !eoc && !win_close && fcnt_r + 5'h01 == lim
      |=> serial_result_oe_n ##1 serial_result_oe_n || cnv_fall || eoc;
  endproperty
  a_float_count: assert property (p_float_count)
    else $error("output not floated at final edge");

  property p_busy_low;
    eoc && !cnv_s && !cnv_rise
      |=> !serial_result_oe_n && !serial_result_out && busy_mode_r;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("busy indication missing");

  property p_mode_pick;
    eoc |=> busy_mode_r == !$past(cnv_s);
  endproperty
  a_mode_pick: assert property (p_mode_pick)
    else $error("mode not taken from start level");

  property p_temp_wrap;
    eoc && !cfg_commit && cfg_r.sequencer_select != 2'b00 &&
      channel_select == `TEMP_CH |=> channel_select == 4'h0;
  endproperty
  a_temp_wrap: assert property (p_temp_wrap)
    else $error("scan did not return to input 0");

  property p_restart;
    eoc && seq_restart && cfg_new.sequencer_select != 2'b00
      |=> channel_select == 4'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("sequence not restarted");

  property p_even_only;
    eoc && !cfg_commit && cfg_r.sequencer_select != 2'b00 &&
      !cfg_r.single_channel && !channel_select[0]
      |=> !channel_select[0];
  endproperty
  a_even_only: assert property (p_even_only)
    else $error("paired scan reached odd input");

endmodule

// file: logic/adc_seq_defs.svh
// constants for the converter serial port and channel sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ====================================================================
// timing
`define CLK_MHZ 200
`define CONV_TIME_NS 2000
`define DATA_TIME_NS 1200
// conversion is a least time: round up; safe window a longest: round down
`define CONV_CYC ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define DATA_CYC ((`DATA_TIME_NS * `CLK_MHZ) / 1000)

// ====================================================================
// serial frame
`define CFG_BITS 4'hE
`define LIM_PLAIN 5'h10
`define LIM_PLAIN_RB 5'h1E
`define LIM_BUSY 5'h11
`define LIM_BUSY_RB 5'h1F
`define CFG_RESET 14'h0001
`define TEMP_CH 4'h8
`define CHANNELS 9

// ====================================================================
// register map (byte addresses)
`define OFF_CFG 12'h000
`define OFF_STATUS 12'h004
`define OFF_SAMPLE_BASE 12'h010
`define SAMPLE_IDX_BASE 4'h4

`endif

// file: logic/adc_seq_pkg.sv
// types for the converter serial port and channel sequencer
package adc_seq_pkg;

  // configuration word as shifted in, msb first
  typedef struct packed {
    logic [1:0] input_mode;
    logic single_channel;
    logic channel_misc;
    logic [2:0] last_channel;
    logic [3:0] filter_ref;
    logic [1:0] sequencer_select;
    logic readback_disable;
  } cfg_t;

  // state of the outgoing result frame
  typedef enum logic [1:0] {
    FR_IDLE,
    FR_ARMED,
    FR_SHIFT
  } frame_t;

endpackage

// file: verif/host_link_model.sv
// host serial controller model that drives the converter link pins
`timescale 1ns/100ps
module host_link_model #(
  parameter int CONV = 40,
  parameter int HP = 12
) (
  input wire logic pclk,
  output logic conversion_start,
  output logic serial_clock,
  output logic config_in,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n
);
  logic [31:0] dat;
  logic [31:0] flt;
  logic rise_flt;

  // ==================================================================
  // pins
  // all pins low at time zero; the link clock stands still between frames
  initial begin
    conversion_start = 1'b0;
    serial_clock = 1'b0;
    config_in = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ==================================================================
  // one conversion, then one read frame of nf link clock periods
  // pins move just after pclk edges; the link clock is 25 pclk long
  task automatic frame(input bit busy, input logic [13:0] cfg,
                       input int nb, input int nf);
    int k;
    serial_clock <= busy; // mode 3 idles high, mode 0 low
    conversion_start <= 1'b1;
    wt(8);
    rise_flt = serial_result_oe_n;
    if (busy) conversion_start <= 1'b0; // low inside window
    wt(CONV + 4); // held past the conversion
    conversion_start <= 1'b0;
    config_in <= (nb > 0) ? cfg[13] : 1'b0; // msb first
    wt(HP);
    // a released line reads as the pull-up's high level
    dat[0] = serial_result_out | serial_result_oe_n;
    flt[0] = serial_result_oe_n;
    for (k = 1; k <= nf; k++) begin
      serial_clock <= ~serial_clock;
      if (busy) config_in <= (k <= nb) ? cfg[14 - k] : 1'b0;
      wt(HP);
      serial_clock <= ~serial_clock;
      if (!busy) config_in <= (k < nb) ? cfg[13 - k] : 1'b0;
      wt(HP + 1);
      // sampled late in the period, well after the falling edge moved it
      dat[k] = serial_result_out | serial_result_oe_n;
      flt[k] = serial_result_oe_n;
    end
  endtask
endmodule

// file: verif/adc_serial_port_sequencer_test.sv
// self-checking bench for the converter serial port and sequencer
`timescale 1ns/100ps
module adc_serial_port_sequencer_test;
  localparam int CONV = 40;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, conversion_start, serial_clock, config_in;
  logic serial_result_out, serial_result_oe_n, converting;
  logic [3:0] channel_select;
  int errors = 0;
  int checked = 0;
  int ccnt = 0;
  logic [31:0] seed = 32'h00006ABC;
  logic [15:0] smp [9];
  logic [13:0] tcfg [23];
  int tnb [23];

  always #2.5 pclk = ~pclk;

  adc_serial_port_sequencer #(.CONV_CYCLES(CONV), .DATA_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .conversion_start(conversion_start), .serial_clock(serial_clock),
    .config_in(config_in), .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n),
    .channel_select(channel_select), .converting(converting));

  host_link_model #(.CONV(CONV), .HP(12)) host (
    .pclk(pclk), .conversion_start(conversion_start),
    .serial_clock(serial_clock), .config_in(config_in),
    .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n));

  // ==================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [13:0] mk(input logic s, input logic [2:0] l,
                                     input logic [1:0] q, input logic rbd);
    adc_seq_pkg::cfg_t c;
    c = '0;
    c.input_mode = 2'h2; // a high first bit marks the word as an update
    c.single_channel = s;
    c.last_channel = l;
    c.sequencer_select = q;
    c.readback_disable = rbd;
    return c;
  endfunction

  // next channel acquired after an end of conversion
  function automatic logic [3:0] step(input logic [3:0] c,
      input logic [13:0] o, input logic [13:0] n, input logic tp);
    logic [3:0] lst;
    lst = {1'b0, n[9:7]};
    if (n[2:1] == 2'h0) return lst;
    if (o[2:1] == 2'h0 || o[11] != n[11] || o[9:7] != n[9:7]) return 4'h0;
    if (c == 4'h8) return 4'h0;
    if (n[11]) return (c >= lst) ? (tp ? 4'h8 : 4'h0) : c + 4'h1;
    return (c + 4'h2 > lst) ? (tp ? 4'h8 : 4'h0) : c + 4'h2;
  endfunction

  task automatic print_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // a started conversion keeps converting high for the whole count
  always @(posedge pclk) begin
    if (converting === 1'b1) ccnt++;
    else if (ccnt != 0) begin
      chk("conversion length", CONV, ccnt);
      ccnt = 0;
    end
  end

  // ==================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic er, busy, tp, pv;
    logic [13:0] cur_cfg, pend, rbw, nxt;
    logic [3:0] cur;
    logic [29:0] st;
    int k, f, nf, len, idx;
    for (k = 0; k < 23; k++) begin
      tcfg[k] = 14'h0000;
      tnb[k] = 0;
    end
    // scan with temperature, then a torn word, update mode, pairs, off
    tcfg[0] = mk(1'b1, 3'h7, 2'h2, 1'b0);
    tnb[0] = 14;
    // torn word rides in the cut frame: only 5 rising clocks reach the port
    tcfg[12] = mk(1'b0, 3'h3, 2'h3, 1'b1);
    tnb[12] = 5;
    tcfg[13] = mk(1'b1, 3'h7, 2'h1, 1'b1);
    tnb[13] = 14;
    tcfg[14] = mk(1'b0, 3'h6, 2'h3, 1'b0);
    tnb[14] = 14;
    tcfg[20] = mk(1'b1, 3'h2, 2'h0, 1'b1);
    tnb[20] = 14;
    tcfg[21] = mk(1'b0, 3'h5, 2'h3, 1'b0);
    tnb[21] = 14;
    repeat (16) @(posedge pclk);
    chk("reset outputs", 32'h00000020, {24'h0, pready, pslverr,
        serial_result_oe_n, converting, channel_select});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00003FFE, rd, er);
    apb(1'b0, 12'h000, 32'h00000000, rd, er);
    chk("cfg reset", 32'h00000001, rd);
    apb(1'b0, 12'h0FC, 32'h00000000, rd, er);
    chk("unmapped error", 32'h00000001, {31'h0, er});
    for (k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      smp[k] = seed[15:0];
      apb(1'b1, 12'h010 + 12'(k * 4), seed, rd, er);
      apb(1'b0, 12'h010 + 12'(k * 4), 32'h00000000, rd, er);
      chk("sample store", {16'h0, smp[k]}, rd);
    end
    cur_cfg = 14'h0001;
    cur = 4'h0;
    pv = 1'b0;
    tp = 1'b0;
    pend = 14'h0000;
    for (f = 0; f < 23; f++) begin
      seed = lfsr(seed);
      // a busy frame drops the start pin before its end of conversion and
      // so throws away a word written earlier; only frame 22 does that
      busy = (f == 22) || (seed[0] && !pv);
      rbw = cur_cfg;
      st = {smp[cur], rbw};
      len = rbw[0] ? 16 : 30;
      nf = (f == 12) ? 5 : len + busy;
      host.frame(busy, tcfg[f], tnb[f], nf);
      // end of conversion: a whole pending word commits, sequencer steps
      nxt = (pv && !busy) ? pend : cur_cfg;
      if (nxt[2:1] != 2'h1) tp = (nxt[2:1] == 2'h2);
      cur = step(cur, cur_cfg, nxt, tp);
      cur_cfg = nxt;
      pv = (tnb[f] == 14);
      pend = tcfg[f];
      chk("float on rise", 1, host.rise_flt);
      for (idx = 0; idx <= nf; idx++) begin
        if (idx == len + busy)
          chk("float at end", 1, host.flt[idx]);
        else if (busy && idx == 0)
          chk("busy low", 0, {host.flt[0], host.dat[0]});
        else
          chk("result bit", {31'h0, st[29 + busy - idx]},
              {host.flt[idx], host.dat[idx]});
      end
      apb(1'b0, 12'h000, 32'h00000000, rd, er);
      chk("cfg in force", {18'h0, cur_cfg}, rd);
      apb(1'b0, 12'h004, 32'h00000000, rd, er);
      chk("status", {24'h0, busy, 3'h0, cur}, rd & 32'h8F);
    end
    print_verdict();
  end
endmodule
